// ### cxs_pkg.sv
// Constants and types shared by the instruction execution block.
// Assumes one 10 MHz instruction clock and a plain register port.
package cxs_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FILE_AW = 7;
    localparam int unsigned FILE_DEPTH = 128;
    localparam int unsigned DIR_PORTS = 3;

    // ****************************************************************
    // Register port offsets
    // ****************************************************************
    localparam logic [7:0] OFS_FILE_LAST = 8'h7F;
    localparam logic [7:0] OFS_ACC = 8'h80;
    localparam logic [7:0] OFS_STATUS = 8'h81;
    localparam logic [7:0] OFS_DIR_A = 8'h82;
    localparam logic [7:0] OFS_DIR_B = 8'h83;
    localparam logic [7:0] OFS_DIR_C = 8'h84;
    localparam logic [7:0] OFS_WDOG = 8'h85;
    localparam logic [7:0] OFS_CORE = 8'h86;

    // ****************************************************************
    // Status field positions
    // ****************************************************************
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_DIGIT_CARRY = 1;
    localparam int unsigned ST_ZERO = 2;
    localparam int unsigned ST_POWER_DOWN = 3;
    localparam int unsigned ST_TIMEOUT = 4;

    // ****************************************************************
    // Values after reset and fixed values
    // ****************************************************************
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] STATUS_MASK = 8'h1F;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_LAST = 8'hFF;

    // ****************************************************************
    // Direction load operand codes
    // ****************************************************************
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;

    // ****************************************************************
    // Instructions
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_SUB,
        OP_SUBB,
        OP_SWAP,
        OP_XORL,
        OP_XORF,
        OP_DIR,
        OP_SLEEP,
        OP_NOP
    } cxs_op_t;

endpackage

// ### cxs_file_ram.sv
// File register memory with one write port and two read ports.
// Assumes the writer resolves conflicts before driving the port.
`timescale 1ns/1ns
module cxs_file_ram (
    input wire logic clk_sys_i,                       // Instruction clock.
    input wire logic we_i,                            // Write enable.
    input wire logic [cxs_pkg::FILE_AW-1:0] waddr_i,  // Write address.
    input wire logic [cxs_pkg::DATA_W-1:0] wdata_i,   // Write data.
    input wire logic [cxs_pkg::FILE_AW-1:0] raddr_a_i, // Operand address.
    output logic [cxs_pkg::DATA_W-1:0] rdata_a_o,     // Operand data.
    input wire logic [cxs_pkg::FILE_AW-1:0] raddr_b_i, // Port address.
    output logic [cxs_pkg::DATA_W-1:0] rdata_b_o      // Port data.
);

    logic [cxs_pkg::DATA_W-1:0] mem [cxs_pkg::FILE_DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_a_o = mem[raddr_a_i];
    assign rdata_b_o = mem[raddr_b_i];

endmodule

// ### cxs_alu.sv
// Result and flag computation for subtract, swap and exclusive-OR.
// Assumes the caller decides which flags are actually written.
`timescale 1ns/1ns
module cxs_alu (
    input wire cxs_pkg::cxs_op_t op_i,             // Instruction.
    input wire logic [cxs_pkg::DATA_W-1:0] acc_i,  // Accumulator.
    input wire logic [cxs_pkg::DATA_W-1:0] fval_i, // File operand.
    input wire logic [cxs_pkg::DATA_W-1:0] lit_i,  // Literal operand.
    input wire logic carry_i,                      // Carry flag now.
    output logic [cxs_pkg::DATA_W-1:0] res_o,      // Result.
    output logic carry_o,                          // Carry out.
    output logic digit_carry_o,                    // Low nibble carry.
    output logic zero_o                            // Result is zero.
);

    logic cin;
    logic [8:0] sum;
    logic [4:0] lo;

    always_comb begin
        // A set carry means no borrow, so the borrow is its inverse.
        cin = (op_i == cxs_pkg::OP_SUBB) ? carry_i : 1'b1;
        // Two's complement: f + ~acc + cin.
        sum = {1'b0, fval_i} + {1'b0, ~acc_i} + {8'h00, cin};
        lo = {1'b0, fval_i[3:0]} + {1'b0, ~acc_i[3:0]} + {4'h0, cin};
        carry_o = sum[8];
        digit_carry_o = lo[4];
        unique case (op_i)
            cxs_pkg::OP_SUB,
            cxs_pkg::OP_SUBB: res_o = sum[7:0];
            cxs_pkg::OP_SWAP: res_o = {fval_i[3:0], fval_i[7:4]};
            cxs_pkg::OP_XORL: res_o = acc_i ^ lit_i;
            cxs_pkg::OP_XORF: res_o = acc_i ^ fval_i;
            cxs_pkg::OP_DIR,
            cxs_pkg::OP_SLEEP,
            cxs_pkg::OP_NOP: res_o = acc_i;
        endcase
        zero_o = (res_o == 8'h00);
    end

endmodule

// ### cxs_core.sv
// Execution unit for subtract, swap, exclusive-OR, direction load and
// sleep, with accumulator, status, direction registers and watchdog.
// Assumes instructions arrive one per cycle synchronous to clk_sys_i.
`timescale 1ns/1ns
module cxs_core (
    input wire logic clk_sys_i,                      // Instruction clock.
    input wire logic nrst_i,                         // Async reset, low.
    input wire logic instr_valid_i,                  // Instruction present.
    output logic instr_ready_o,                      // Core is awake.
    input wire cxs_pkg::cxs_op_t op_i,               // Instruction code.
    input wire logic [cxs_pkg::FILE_AW-1:0] faddr_i, // File operand.
    input wire logic dest_i,                         // 1 selects file.
    input wire logic [cxs_pkg::DATA_W-1:0] lit_i,    // Literal operand.
    input wire logic wake_i,                         // Wake event level.
    input wire logic [cxs_pkg::ADDR_W-1:0] reg_addr_i, // Register address.
    input wire logic [cxs_pkg::DATA_W-1:0] reg_wdata_i, // Write data.
    input wire logic reg_we_i,                       // Write strobe.
    input wire logic reg_re_i,                       // Read strobe.
    output logic [cxs_pkg::DATA_W-1:0] reg_rdata_o,  // Read data.
    output logic [cxs_pkg::DATA_W-1:0] dir_a_o,      // Port A direction.
    output logic [cxs_pkg::DATA_W-1:0] dir_b_o,      // Port B direction.
    output logic [cxs_pkg::DATA_W-1:0] dir_c_o,      // Port C direction.
    output logic osc_en_o,                           // Oscillator runs.
    output logic sleep_o,                            // Sleep state.
    output logic wdog_clr_o                          // Watchdog cleared.
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] acc_q, acc_d, status_q, status_d;
    logic [7:0] dir_q [cxs_pkg::DIR_PORTS];
    logic [7:0] dir_d [cxs_pkg::DIR_PORTS];
    logic sleep_q, sleep_d, wdog_clr_q, wdog_clr_d;
    logic [7:0] wdog_q, wdog_d, pre_q, pre_d, rdata_q, rdata_d;
    logic exec, file_op, reg_file, mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata, fval, bus_fval, alu_res;
    logic alu_c, alu_nib_c, alu_z;
    assign exec = instr_valid_i & ~sleep_q;
    assign instr_ready_o = ~sleep_q;
    assign file_op = (op_i == cxs_pkg::OP_SUB) | (op_i == cxs_pkg::OP_SUBB)
                   | (op_i == cxs_pkg::OP_SWAP) | (op_i == cxs_pkg::OP_XORF);
    assign reg_file = (reg_addr_i <= cxs_pkg::OFS_FILE_LAST);

    // ****************************************************************
    // Datapath
    // ****************************************************************
    cxs_alu u_alu (
        .op_i(op_i),
        .acc_i(acc_q),
        .fval_i(fval),
        .lit_i(lit_i),
        .carry_i(status_q[cxs_pkg::ST_CARRY]),
        .res_o(alu_res),
        .carry_o(alu_c),
        .digit_carry_o(alu_nib_c),
        .zero_o(alu_z)
    );

    // An instruction write to the file wins over a port write.
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = faddr_i;
        mem_wdata = alu_res;
        if (exec && file_op && dest_i) begin
            mem_we = 1'b1;
        end else if (reg_we_i && reg_file) begin
            mem_we = 1'b1;
            mem_waddr = reg_addr_i[6:0];
            mem_wdata = reg_wdata_i;
        end
    end

    cxs_file_ram u_ram (
        .clk_sys_i(clk_sys_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_a_i(faddr_i),
        .rdata_a_o(fval),
        .raddr_b_i(reg_addr_i[6:0]),
        .rdata_b_o(bus_fval)
    );

    // ****************************************************************
    // Architectural state
    // ****************************************************************
    // A port write to a core register is dropped in an execute cycle.
    always_comb begin
        acc_d = acc_q;
        status_d = status_q;
        dir_d = dir_q;
        if (exec) begin
            unique case (op_i)
                cxs_pkg::OP_SUB,
                cxs_pkg::OP_SUBB: begin
                    status_d[cxs_pkg::ST_CARRY] = alu_c;
                    status_d[cxs_pkg::ST_DIGIT_CARRY] = alu_nib_c;
                    status_d[cxs_pkg::ST_ZERO] = alu_z;
                    if (!dest_i) begin
                        acc_d = alu_res;
                    end
                end
                cxs_pkg::OP_SWAP: begin
                    if (!dest_i) begin
                        acc_d = alu_res;
                    end
                end
                cxs_pkg::OP_XORL: begin
                    acc_d = alu_res;
                    status_d[cxs_pkg::ST_ZERO] = alu_z;
                end
                cxs_pkg::OP_XORF: begin
                    status_d[cxs_pkg::ST_ZERO] = alu_z;
                    if (!dest_i) begin
                        acc_d = alu_res;
                    end
                end
                cxs_pkg::OP_DIR: begin
                    unique case (faddr_i)
                        cxs_pkg::DIR_SEL_A: dir_d[0] = acc_q;
                        cxs_pkg::DIR_SEL_B: dir_d[1] = acc_q;
                        cxs_pkg::DIR_SEL_C: dir_d[2] = acc_q;
                        default: dir_d = dir_q;
                    endcase
                end
                cxs_pkg::OP_SLEEP: begin
                    status_d[cxs_pkg::ST_TIMEOUT] = 1'b1;
                    status_d[cxs_pkg::ST_POWER_DOWN] = 1'b0;
                end
                cxs_pkg::OP_NOP: acc_d = acc_q;
            endcase
        end else if (reg_we_i) begin
            unique case (reg_addr_i)
                cxs_pkg::OFS_ACC: acc_d = reg_wdata_i;
                cxs_pkg::OFS_STATUS:
                    status_d = reg_wdata_i & cxs_pkg::STATUS_MASK;
                cxs_pkg::OFS_DIR_A: dir_d[0] = reg_wdata_i;
                cxs_pkg::OFS_DIR_B: dir_d[1] = reg_wdata_i;
                cxs_pkg::OFS_DIR_C: dir_d[2] = reg_wdata_i;
                default: acc_d = acc_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= cxs_pkg::ACC_RST;
            status_q <= cxs_pkg::STATUS_RST;
        end else begin
            acc_q <= acc_d;
            status_q <= status_d;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < cxs_pkg::DIR_PORTS; gi++) begin : g_dir
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    dir_q[gi] <= cxs_pkg::DIR_RST;
                end else begin
                    dir_q[gi] <= dir_d[gi];
                end
            end
        end
    endgenerate
    assign dir_a_o = dir_q[0];
    assign dir_b_o = dir_q[1];
    assign dir_c_o = dir_q[2];

    // ****************************************************************
    // Sleep and watchdog
    // ****************************************************************
    // The watchdog runs on its own and keeps counting during sleep.
    always_comb begin
        sleep_d = sleep_q;
        wdog_clr_d = 1'b0;
        pre_d = pre_q + 8'h01;
        wdog_d = (pre_q == cxs_pkg::PRESCALE_LAST) ? wdog_q + 8'h01 : wdog_q;
        if (sleep_q && wake_i) begin
            sleep_d = 1'b0;
        end
        if (exec && op_i == cxs_pkg::OP_SLEEP) begin
            sleep_d = 1'b1;
            wdog_clr_d = 1'b1;
            pre_d = cxs_pkg::PRESCALE_CLEAR;
            wdog_d = cxs_pkg::WDOG_CLEAR;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sleep_q <= 1'b0;
            wdog_clr_q <= 1'b0;
            pre_q <= cxs_pkg::PRESCALE_CLEAR;
            wdog_q <= cxs_pkg::WDOG_CLEAR;
        end else begin
            sleep_q <= sleep_d;
            wdog_clr_q <= wdog_clr_d;
            pre_q <= pre_d;
            wdog_q <= wdog_d;
        end
    end
    assign sleep_o = sleep_q;
    assign osc_en_o = ~sleep_q;
    assign wdog_clr_o = wdog_clr_q;

    // ****************************************************************
    // Register port read
    // ****************************************************************
    always_comb begin
        rdata_d = 8'h00;
        if (reg_re_i) begin
            if (reg_file) begin
                rdata_d = bus_fval;
            end else begin
                unique case (reg_addr_i)
                    cxs_pkg::OFS_ACC: rdata_d = acc_q;
                    cxs_pkg::OFS_STATUS: rdata_d = status_q;
                    cxs_pkg::OFS_DIR_A: rdata_d = dir_q[0];
                    cxs_pkg::OFS_DIR_B: rdata_d = dir_q[1];
                    cxs_pkg::OFS_DIR_C: rdata_d = dir_q[2];
                    cxs_pkg::OFS_WDOG: rdata_d = wdog_q;
                    cxs_pkg::OFS_CORE: rdata_d = {7'h00, sleep_q};
                    default: rdata_d = 8'h00;
                endcase
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_sleep_flags;
        exec && op_i == cxs_pkg::OP_SLEEP |=>
            status_q[cxs_pkg::ST_TIMEOUT] && !status_q[cxs_pkg::ST_POWER_DOWN]
            && wdog_q == 8'h00 && pre_q == 8'h00 && wdog_clr_o;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("sleep did not clear watchdog or set flags");
    property p_sleep_halt;
        exec && op_i == cxs_pkg::OP_SLEEP ##1 !wake_i |->
            sleep_o && !osc_en_o && !instr_ready_o ##1 sleep_o;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt)
        else $error("core left sleep without a wake event");
    property p_sub_res;
        exec && op_i == cxs_pkg::OP_SUB && !dest_i |=>
            acc_q == 8'($past(fval) - $past(acc_q));
    endproperty
    a_sub_res: assert property (p_sub_res)
        else $error("subtract result wrong");
    property p_dest_file;
        exec && file_op && dest_i |-> mem_we && mem_waddr == faddr_i
            ##1 acc_q == $past(acc_q);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file destination not honoured");
    property p_sub_flags;
        exec && op_i == cxs_pkg::OP_SUB |=>
            status_q[cxs_pkg::ST_CARRY] == ($past(acc_q) <= $past(fval))
            && status_q[cxs_pkg::ST_DIGIT_CARRY] ==
               ($past(acc_q[3:0]) <= $past(fval[3:0]));
    endproperty
    a_sub_flags: assert property (p_sub_flags)
        else $error("subtract carry flags wrong");
    property p_subb_res;
        exec && op_i == cxs_pkg::OP_SUBB && !dest_i |=>
            acc_q == 8'($past(fval) - $past(acc_q)
                - {7'h00, !$past(status_q[cxs_pkg::ST_CARRY])});
    endproperty
    a_subb_res: assert property (p_subb_res)
        else $error("borrow subtract result wrong");
    property p_swap;
        exec && op_i == cxs_pkg::OP_SWAP && !dest_i |=>
            acc_q == {$past(fval[3:0]), $past(fval[7:4])}
            && $stable(status_q);
    endproperty
    a_swap: assert property (p_swap)
        else $error("swap result or flags wrong");
    property p_xorl;
        exec && op_i == cxs_pkg::OP_XORL |=>
            acc_q == ($past(acc_q) ^ $past(lit_i))
            && $stable(status_q[cxs_pkg::ST_DIGIT_CARRY:cxs_pkg::ST_CARRY]);
    endproperty
    a_xorl: assert property (p_xorl)
        else $error("literal XOR wrong");
    property p_xorf;
        exec && op_i == cxs_pkg::OP_XORF && !dest_i |=>
            acc_q == ($past(acc_q) ^ $past(fval))
            && $stable(status_q[cxs_pkg::ST_DIGIT_CARRY:cxs_pkg::ST_CARRY]);
    endproperty
    a_xorf: assert property (p_xorf)
        else $error("file XOR wrong");
    property p_dir;
        exec && op_i == cxs_pkg::OP_DIR && faddr_i == cxs_pkg::DIR_SEL_B |=>
            dir_b_o == $past(acc_q) && $stable(dir_a_o) && $stable(status_q);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction load wrong");
    property p_zero;
        exec && (file_op || op_i == cxs_pkg::OP_XORL)
            && op_i != cxs_pkg::OP_SWAP |=>
            status_q[cxs_pkg::ST_ZERO] == ($past(alu_res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    c_wake: cover property (sleep_o && wake_i ##1 instr_ready_o);
    c_subb: cover property (exec && op_i == cxs_pkg::OP_SUBB && dest_i);
    c_dir: cover property (exec && op_i == cxs_pkg::OP_DIR);
    c_xorf: cover property (exec && op_i == cxs_pkg::OP_XORF && alu_z);

endmodule

// ### tb.sv
// Self-checking testbench for the instruction execution block cxs_core.
// Assumes the design files are compiled first and hold their assertions.
`timescale 1ns/1ns
module tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk_sys_i, nrst_i, instr_valid_i, dest_i, wake_i;
    logic reg_we_i, reg_re_i;
    cxs_pkg::cxs_op_t op_i;
    logic [6:0] faddr_i;
    logic [7:0] lit_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [7:0] dir_a_o, dir_b_o, dir_c_o;
    logic instr_ready_o, osc_en_o, sleep_o, wdog_clr_o;
    int miscompares, cmp_count;

    cxs_core i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
        .op_i(op_i), .faddr_i(faddr_i), .dest_i(dest_i), .lit_i(lit_i),
        .wake_i(wake_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .dir_a_o(dir_a_o), .dir_b_o(dir_b_o), .dir_c_o(dir_c_o),
        .osc_en_o(osc_en_o), .sleep_o(sleep_o), .wdog_clr_o(wdog_clr_o));

    // ****************************************************************
    // Clock, report and access tasks
    // ****************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: byte got %h expected %h", $time,
                got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: flag got %b expected %b", $time,
                got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_we_i <= 1'b0;
    endtask

    // The read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_re_i <= 1'b0;
        #10;
        chk8(reg_rdata_o, exp);
    endtask

    task automatic exec(input cxs_pkg::cxs_op_t op, input logic [6:0] fa,
                        input logic d, input logic [7:0] k);
        @(posedge clk_sys_i);
        op_i <= op;
        faddr_i <= fa;
        dest_i <= d;
        lit_i <= k;
        instr_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        op_i <= cxs_pkg::OP_NOP;
    endtask

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        miscompares = 0;
        cmp_count = 0;
        nrst_i = 1'b0;
        instr_valid_i = 1'b0;
        op_i = cxs_pkg::OP_NOP;
        faddr_i = 7'h00;
        dest_i = 1'b0;
        lit_i = 8'h00;
        wake_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        reg_rd(8'h81, 8'h18);
        reg_rd(8'h90, 8'h00);
        chk8(dir_b_o, 8'hFF);
        // Subtract at the top file address, both destinations.
        reg_wr(8'h7F, 8'h05);
        reg_wr(8'h80, 8'h03);
        exec(cxs_pkg::OP_SUB, 7'h7F, 1'b0, 8'h00);
        reg_rd(8'h80, 8'h02);
        reg_rd(8'h81, 8'h1B);
        reg_wr(8'h80, 8'h05);
        exec(cxs_pkg::OP_SUB, 7'h7F, 1'b1, 8'h00);
        reg_rd(8'h7F, 8'h00);
        reg_rd(8'h80, 8'h05);
        reg_rd(8'h81, 8'h1F);
        reg_wr(8'h7F, 8'h05);
        reg_wr(8'h80, 8'h06);
        exec(cxs_pkg::OP_SUB, 7'h7F, 1'b0, 8'h00);
        reg_rd(8'h80, 8'hFF);
        reg_rd(8'h81, 8'h18);
        // Borrow subtract with carry clear, then with carry set.
        reg_wr(8'h00, 8'h10);
        reg_wr(8'h80, 8'h01);
        exec(cxs_pkg::OP_SUBB, 7'h00, 1'b0, 8'h00);
        reg_rd(8'h80, 8'h0E);
        reg_rd(8'h81, 8'h19);
        reg_wr(8'h00, 8'h05);
        reg_wr(8'h80, 8'h05);
        exec(cxs_pkg::OP_SUBB, 7'h00, 1'b1, 8'h00);
        reg_rd(8'h00, 8'h00);
        reg_rd(8'h81, 8'h1F);
        // Swap keeps every flag.
        reg_wr(8'h00, 8'hA5);
        exec(cxs_pkg::OP_SWAP, 7'h00, 1'b0, 8'h00);
        reg_rd(8'h80, 8'h5A);
        exec(cxs_pkg::OP_SWAP, 7'h00, 1'b1, 8'h00);
        reg_rd(8'h00, 8'h5A);
        reg_rd(8'h81, 8'h1F);
        // Literal form always lands in the accumulator.
        exec(cxs_pkg::OP_XORL, 7'h00, 1'b1, 8'hFF);
        reg_rd(8'h80, 8'hA5);
        reg_rd(8'h00, 8'h5A);
        reg_rd(8'h81, 8'h1B);
        exec(cxs_pkg::OP_XORF, 7'h00, 1'b1, 8'h00);
        reg_rd(8'h00, 8'hFF);
        reg_wr(8'h80, 8'hFF);
        exec(cxs_pkg::OP_XORF, 7'h00, 1'b0, 8'h00);
        reg_rd(8'h80, 8'h00);
        reg_rd(8'h81, 8'h1F);
        // Direction loads for every port, then codes out of range.
        for (int i = 0; i < 3; i++) begin
            reg_wr(8'h80, 8'h3C + 8'(i));
            exec(cxs_pkg::OP_DIR, cxs_pkg::DIR_SEL_A + 7'(i), 1'b0, 8'h00);
        end
        exec(cxs_pkg::OP_DIR, 7'h04, 1'b0, 8'h00);
        exec(cxs_pkg::OP_DIR, 7'h08, 1'b0, 8'h00);
        chk8(dir_a_o, 8'h3C);
        chk8(dir_b_o, 8'h3D);
        chk8(dir_c_o, 8'h3E);
        reg_rd(8'h81, 8'h1F);
        // Sleep, an ignored instruction, then wake.
        reg_wr(8'h81, 8'h0F);
        exec(cxs_pkg::OP_SLEEP, 7'h00, 1'b0, 8'h00);
        #10;
        chk1(wdog_clr_o, 1'b1);
        chk1(sleep_o, 1'b1);
        chk1(osc_en_o, 1'b0);
        chk1(instr_ready_o, 1'b0);
        @(posedge clk_sys_i);
        #10;
        chk1(wdog_clr_o, 1'b0);
        reg_rd(8'h81, 8'h17);
        reg_rd(8'h85, 8'h00);
        exec(cxs_pkg::OP_XORL, 7'h00, 1'b0, 8'hFF);
        reg_rd(8'h80, 8'h3E);
        reg_rd(8'h86, 8'h01);
        @(posedge clk_sys_i);
        wake_i <= 1'b1;
        @(posedge clk_sys_i);
        wake_i <= 1'b0;
        #10;
        chk1(sleep_o, 1'b0);
        chk1(instr_ready_o, 1'b1);
        chk1(osc_en_o, 1'b1);
        reg_rd(8'h86, 8'h00);
        exec(cxs_pkg::OP_XORL, 7'h00, 1'b0, 8'h3E);
        reg_rd(8'h80, 8'h00);
        tally_and_finish();
    end
endmodule
